/* verilog/hdtf_cfg.svh */
`ifndef HDTF_CFG_SVH
`define HDTF_CFG_SVH

// register offsets on the plain register port
`define HDTF_ADDR_W 3
`define HDTF_OFS_DATA 3'h0
`define HDTF_OFS_CMD 3'h1
`define HDTF_OFS_IRQ 3'h2
`define HDTF_OFS_STAT 3'h3
`define HDTF_OFS_EXM 3'h4

// command register bits
`define HDTF_CMD_SEND_FRAME 0
`define HDTF_CMD_MSG_END 1
`define HDTF_CMD_TX_RESET 2

// interrupt status bits
`define HDTF_IRQ_W 3
`define HDTF_IRQ_POOL_READY 0
`define HDTF_IRQ_UNDERRUN 1
`define HDTF_IRQ_MSG_REPEAT 2

// channel status bits
`define HDTF_STAT_WRITE_EN 0
`define HDTF_STAT_OVERFLOW 1

// extended mode bits and reset value
`define HDTF_EXM_W 3
`define HDTF_EXM_BS16 0
`define HDTF_EXM_CRC_OFF 1
`define HDTF_EXM_IDLE_ONES 2
`define HDTF_EXM_RST 3'h0

// buffer sizes and block thresholds
`define HDTF_MEM_DEPTH 128
`define HDTF_DEPTH_D 8'h40
`define HDTF_DEPTH_B 8'h80
`define HDTF_BS_SMALL 8'h10
`define HDTF_BS_LARGE 8'h20

// line patterns
`define HDTF_FLAG 8'h7e
`define HDTF_ONES 8'hff
`define HDTF_ABORT_BITS 4'h7
`define HDTF_CRC_INIT 16'hffff
`define HDTF_CRC_POLY 16'h8408

`endif

/* verilog/hdtf_pkg.sv */
package hdtf_pkg;
	`include "hdtf_cfg.svh"

	typedef enum logic [2:0] {
		TX_IDLE,
		TX_OPEN,
		TX_DATA,
		TX_CRC,
		TX_CLOSE,
		TX_ABORT
	} hdtf_txst_t;

	typedef struct packed {
		logic [`HDTF_MEM_DEPTH-1:0][8:0] mem;
		logic [7:0] wrPtr;
		logic [7:0] rdPtr;
		logic [7:0] relPtr;
		logic [7:0] commitPtr;
		logic [7:0] blkCnt;
		logic [7:0] sentCnt;
		logic [`HDTF_IRQ_W-1:0] irq;
		logic overflow;
		logic bs32;
		logic crcEn;
		logic idleOnes;
		logic [`HDTF_EXM_W-1:0] exm;
		logic armPr;
		logic lockPr;
		logic abortPend;
		logic blkRel;
		logic lastLd;
		logic crcHi;
		hdtf_txst_t st;
		logic [7:0] sh;
		logic [3:0] bitLeft;
		logic [2:0] ones;
		logic [15:0] crc;
		logic txBit;
		logic [7:0] rdData;
	} hdtf_state_t;
endpackage

/* verilog/hdtf_tx_fifo.sv */
// Added by the designer: the address map and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none

module hdtf_tx_fifo #(
	parameter bit IS_D_CHAN = 1'b1
) (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [`HDTF_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	output logic [7:0] regRdData,
	input wire logic bitEn,
	input wire logic chanStop,
	output logic txBit
);
	import hdtf_pkg::*;

	localparam logic [7:0] DEPTH = IS_D_CHAN ? `HDTF_DEPTH_D : `HDTF_DEPTH_B;

	hdtf_state_t s_r;
	hdtf_state_t s_nxt;

	logic [7:0] bsNow;
	logic [7:0] used;
	logic [7:0] freeSp;
	logic lockErr;
	logic wrOpen;
	logic wrEnFlag;

	// index wraps at the channel depth, pointers run modulo 256
	function automatic logic [6:0] idxOf(input logic [7:0] p);
		logic [7:0] m;
		m = p & (DEPTH - 8'h01);
		return m[6:0];
	endfunction

	function automatic logic stuffable(input hdtf_txst_t st);
		return (st == TX_DATA) || (st == TX_CRC);
	endfunction

	// status terms seen by the host
	always_comb begin
		bsNow = s_r.bs32 ? `HDTF_BS_LARGE : `HDTF_BS_SMALL;
		used = s_r.wrPtr - s_r.relPtr;
		freeSp = DEPTH - used;
		lockErr = s_r.irq[`HDTF_IRQ_UNDERRUN] | s_r.irq[`HDTF_IRQ_MSG_REPEAT];
		wrOpen = !lockErr && !s_r.lockPr && (used < DEPTH);
		wrEnFlag = !lockErr && !s_r.lockPr && (freeSp >= bsNow);
	end

	// next-state: host access first, then the bit engine
	always_comb begin
		logic [`HDTF_IRQ_W-1:0] irqSet;
		logic [`HDTF_IRQ_W-1:0] irqClr;
		logic ld;
		logic flush;
		logic b;
		logic fb;
		logic [8:0] ent;
		logic [7:0] avail;
		logic [7:0] bsN;
		irqSet = '0;
		irqClr = '0;
		ld = 1'b0;
		flush = 1'b0;
		b = 1'b1;
		fb = 1'b0;
		ent = '0;
		avail = '0;
		bsN = '0;
		s_nxt = s_r;
		s_nxt.rdData = 8'h00;

		// register reads, answer stands one cycle
		if (regRd) begin
			case (regAddr)
				`HDTF_OFS_IRQ: begin
					s_nxt.rdData = {5'h00, s_r.irq};
					irqClr = s_r.irq;
				end
				`HDTF_OFS_STAT: begin
					s_nxt.rdData = {6'h00, s_r.overflow, wrEnFlag};
				end
				`HDTF_OFS_EXM: begin
					s_nxt.rdData = {5'h00, s_r.exm};
				end
				default: begin
					s_nxt.rdData = 8'h00;
				end
			endcase
		end

		// register writes
		if (regWr) begin
			case (regAddr)
				`HDTF_OFS_DATA: begin
					if (wrOpen) begin
						s_nxt.mem[idxOf(s_r.wrPtr)] = {1'b0, regWrData};
						s_nxt.wrPtr = s_r.wrPtr + 8'h01;
						s_nxt.blkCnt = s_r.blkCnt + 8'h01;
						if (s_r.blkCnt >= bsNow) begin
							s_nxt.overflow = 1'b1;
						end
					end
				end
				`HDTF_OFS_CMD: begin
					if (regWrData[`HDTF_CMD_TX_RESET]) begin
						// pending flags are left alone here
						flush = 1'b1;
						s_nxt.abortPend = 1'b1;
						s_nxt.st = TX_IDLE;
						s_nxt.bitLeft = 4'h0;
						s_nxt.ones = 3'h0;
						s_nxt.overflow = 1'b0;
						s_nxt.armPr = 1'b0;
						s_nxt.lockPr = 1'b0;
						s_nxt.bs32 = !IS_D_CHAN || !s_r.exm[`HDTF_EXM_BS16];
						s_nxt.idleOnes = s_r.exm[`HDTF_EXM_IDLE_ONES];
						irqSet[`HDTF_IRQ_POOL_READY] = 1'b1;
					end else if (regWrData[`HDTF_CMD_SEND_FRAME] ||
						regWrData[`HDTF_CMD_MSG_END]) begin
						s_nxt.commitPtr = s_r.wrPtr;
						s_nxt.blkCnt = 8'h00;
						s_nxt.bs32 = !IS_D_CHAN || !s_r.exm[`HDTF_EXM_BS16];
						if (regWrData[`HDTF_CMD_MSG_END] && (s_r.blkCnt != 8'h00)) begin
							s_nxt.mem[idxOf(s_r.wrPtr - 8'h01)][8] = 1'b1;
						end
						if (regWrData[`HDTF_CMD_SEND_FRAME] && regWrData[`HDTF_CMD_MSG_END]) begin
							s_nxt.lockPr = 1'b1;
						end else begin
							s_nxt.armPr = 1'b1;
						end
					end
				end
				`HDTF_OFS_EXM: begin
					s_nxt.exm = regWrData[`HDTF_EXM_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// collision on the D-channel while a frame is on the line
		if (IS_D_CHAN && chanStop && (s_nxt.st != TX_IDLE) && (s_nxt.st != TX_ABORT)) begin
			if (!s_nxt.blkRel) begin
				// first block still held, so rewind and retry quietly
				s_nxt.rdPtr = s_nxt.relPtr;
				s_nxt.lastLd = 1'b0;
				s_nxt.sentCnt = 8'h00;
			end else begin
				irqSet[`HDTF_IRQ_MSG_REPEAT] = 1'b1;
				flush = 1'b1;
			end
			s_nxt.st = TX_IDLE;
			s_nxt.bitLeft = 4'h0;
			s_nxt.ones = 3'h0;
		end

		// bit engine, one bit per enable from the time slot
		bsN = s_nxt.bs32 ? `HDTF_BS_LARGE : `HDTF_BS_SMALL;
		if (bitEn) begin
			if (stuffable(s_nxt.st) && (s_nxt.ones == 3'h5)) begin
				// zero insertion after five ones
				s_nxt.txBit = 1'b0;
				s_nxt.ones = 3'h0;
			end else begin
				avail = s_nxt.commitPtr - s_nxt.rdPtr;
				if (s_nxt.bitLeft == 4'h0) begin
					case (s_nxt.st)
						TX_IDLE, TX_ABORT: begin
							if (s_nxt.abortPend) begin
								s_nxt.abortPend = 1'b0;
								s_nxt.st = TX_ABORT;
								s_nxt.sh = `HDTF_ONES;
								s_nxt.bitLeft = `HDTF_ABORT_BITS;
							end else if (avail != 8'h00) begin
								s_nxt.st = TX_OPEN;
								s_nxt.sh = `HDTF_FLAG;
								s_nxt.bitLeft = 4'h8;
								s_nxt.crc = `HDTF_CRC_INIT;
								s_nxt.crcEn = !s_nxt.exm[`HDTF_EXM_CRC_OFF];
								s_nxt.blkRel = 1'b0;
								s_nxt.sentCnt = 8'h00;
							end else begin
								s_nxt.st = TX_IDLE;
								s_nxt.sh = s_nxt.idleOnes ? `HDTF_ONES : `HDTF_FLAG;
								s_nxt.bitLeft = 4'h8;
							end
						end
						TX_OPEN: begin
							ld = 1'b1;
						end
						TX_DATA: begin
							if (s_nxt.sentCnt >= bsN) begin
								// whole block has left, hand its space back
								s_nxt.relPtr = s_nxt.rdPtr;
								s_nxt.blkRel = 1'b1;
								s_nxt.sentCnt = 8'h00;
							end
							if (s_nxt.lastLd) begin
								s_nxt.lastLd = 1'b0;
								if (s_nxt.crcEn) begin
									s_nxt.st = TX_CRC;
									s_nxt.sh = ~s_nxt.crc[7:0];
									s_nxt.crcHi = 1'b0;
								end else begin
									s_nxt.st = TX_CLOSE;
									s_nxt.sh = `HDTF_FLAG;
								end
								s_nxt.bitLeft = 4'h8;
							end else if (avail != 8'h00) begin
								ld = 1'b1;
							end else begin
								// host too slow, abort the frame on the line
								s_nxt.st = TX_ABORT;
								s_nxt.sh = `HDTF_ONES;
								s_nxt.bitLeft = `HDTF_ABORT_BITS;
								irqSet[`HDTF_IRQ_UNDERRUN] = 1'b1;
								flush = 1'b1;
							end
						end
						TX_CRC: begin
							if (!s_nxt.crcHi) begin
								s_nxt.sh = ~s_nxt.crc[15:8];
								s_nxt.crcHi = 1'b1;
							end else begin
								s_nxt.st = TX_CLOSE;
								s_nxt.sh = `HDTF_FLAG;
							end
							s_nxt.bitLeft = 4'h8;
						end
						TX_CLOSE: begin
							s_nxt.relPtr = s_nxt.rdPtr;
							s_nxt.blkRel = 1'b0;
							s_nxt.sentCnt = 8'h00;
							s_nxt.idleOnes = s_nxt.exm[`HDTF_EXM_IDLE_ONES];
							if (s_nxt.lockPr) begin
								s_nxt.lockPr = 1'b0;
								irqSet[`HDTF_IRQ_POOL_READY] = 1'b1;
							end
							if (avail != 8'h00) begin
								// closing flag doubles as the next opening flag
								ld = 1'b1;
								s_nxt.crc = `HDTF_CRC_INIT;
								s_nxt.crcEn = !s_nxt.exm[`HDTF_EXM_CRC_OFF];
							end else begin
								s_nxt.st = TX_IDLE;
								s_nxt.sh = s_nxt.idleOnes ? `HDTF_ONES : `HDTF_FLAG;
								s_nxt.bitLeft = 4'h8;
							end
						end
						default: begin
							s_nxt.st = TX_IDLE;
							s_nxt.sh = `HDTF_ONES;
							s_nxt.bitLeft = 4'h8;
						end
					endcase
				end

				// fetch the next committed byte
				if (ld) begin
					ent = s_nxt.mem[idxOf(s_nxt.rdPtr)];
					s_nxt.sh = ent[7:0];
					s_nxt.lastLd = ent[8];
					s_nxt.rdPtr = s_nxt.rdPtr + 8'h01;
					s_nxt.sentCnt = s_nxt.sentCnt + 8'h01;
					s_nxt.bitLeft = 4'h8;
					s_nxt.st = TX_DATA;
				end

				// shift out lsb first, track ones and check sum
				b = s_nxt.sh[0];
				s_nxt.txBit = b;
				s_nxt.sh = {1'b1, s_nxt.sh[7:1]};
				s_nxt.bitLeft = s_nxt.bitLeft - 4'h1;
				if (stuffable(s_nxt.st)) begin
					s_nxt.ones = b ? (s_nxt.ones + 3'h1) : 3'h0;
				end else begin
					s_nxt.ones = 3'h0;
				end
				if (s_nxt.st == TX_DATA) begin
					fb = s_nxt.crc[0] ^ b;
					s_nxt.crc = {1'b0, s_nxt.crc[15:1]} ^ (fb ? `HDTF_CRC_POLY : 16'h0000);
				end
			end
		end

		// emptying the buffer drops every byte not yet on the line
		if (flush) begin
			s_nxt.wrPtr = 8'h00;
			s_nxt.rdPtr = 8'h00;
			s_nxt.relPtr = 8'h00;
			s_nxt.commitPtr = 8'h00;
			s_nxt.blkCnt = 8'h00;
			s_nxt.sentCnt = 8'h00;
			s_nxt.blkRel = 1'b0;
			s_nxt.lastLd = 1'b0;
			s_nxt.lockPr = 1'b0;
		end

		// armed pool ready fires once a block of space is free
		if (s_nxt.armPr && ((DEPTH - (s_nxt.wrPtr - s_nxt.relPtr)) >= bsN)) begin
			s_nxt.armPr = 1'b0;
			irqSet[`HDTF_IRQ_POOL_READY] = 1'b1;
		end

		// a new event wins over the read that clears
		s_nxt.irq = (s_r.irq & ~irqClr) | irqSet;
	end

	// single state register
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			s_r <= '0;
			s_r.bs32 <= 1'b1;
			s_r.exm <= `HDTF_EXM_RST;
			s_r.st <= TX_IDLE;
			s_r.sh <= `HDTF_ONES;
			s_r.crc <= `HDTF_CRC_INIT;
			s_r.crcEn <= 1'b1;
			s_r.txBit <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign regRdData = s_r.rdData;
	assign txBit = s_r.txBit;
endmodule

`default_nettype wire

/* tb/hdtf_tx_fifo_checker.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hdtf_cfg.svh"
module hdtf_tx_fifo_checker (
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [`HDTF_ADDR_W-1:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [7:0] regRdData,
	input wire logic bitEn,
	input wire logic txBit
);
	logic cmdRes, irqRd, statRd, resPend_r, wrSince_r;
	logic [5:0] age_r;
	logic [2:0] abCnt_r;
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// decoded bus events
	assign cmdRes = regWr && regAddr == `HDTF_OFS_CMD && regWrData[`HDTF_CMD_TX_RESET];
	assign irqRd = regRd && regAddr == `HDTF_OFS_IRQ;
	assign statRd = regRd && regAddr == `HDTF_OFS_STAT;
	// reset bookkeeping; age saturates so old resets still count
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			resPend_r <= 1'b0;
			wrSince_r <= 1'b0;
			age_r <= 6'h00;
			abCnt_r <= 3'h0;
		end else begin
			resPend_r <= cmdRes || (resPend_r && !irqRd);
			wrSince_r <= !cmdRes && (wrSince_r || (regWr && regAddr == `HDTF_OFS_DATA));
			age_r <= cmdRes ? 6'h00 : age_r + 6'(age_r != 6'h3f);
			// an enable in the command cycle already carries the first abort bit
			abCnt_r <= cmdRes ? (bitEn ? 3'h6 : 3'h7) : abCnt_r - 3'(bitEn && abCnt_r != 3'h0);
		end
	end
	line_hold_a: assert property (!bitEn |=> $stable(txBit))
		else $error("line bit moved without bit enable");
	pool_after_reset_a: assert property (irqRd && resPend_r && age_r >= 6'h28 |=> regRdData[0])
		else $error("no pool ready after transmitter reset");
	abort_ones_a: assert property (bitEn && (cmdRes || abCnt_r != 3'h0) |=> txBit)
		else $error("abort after reset not all ones");
	read_idle_a: assert property (!regRd |=> regRdData == 8'h00)
		else $error("read data outside answer cycle");
	irq_bits_a: assert property (irqRd |=> regRdData[7:3] == 5'h00)
		else $error("unused interrupt bits set");
	stat_bits_a: assert property (statRd |=> regRdData[7:2] == 6'h00)
		else $error("unused status bits set");
	ovf_clear_a: assert property (statRd && !wrSince_r |=> !regRdData[1])
		else $error("overflow without data written");
	unmapped_read_a: assert property (regRd && regAddr > `HDTF_OFS_EXM |=> regRdData == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind hdtf_tx_fifo hdtf_tx_fifo_checker hdtf_chk (
	.mclk(mclk),
	.rst_b(rst_b),
	.regAddr(regAddr),
	.regWrData(regWrData),
	.regWr(regWr),
	.regRd(regRd),
	.regRdData(regRdData),
	.bitEn(bitEn),
	.txBit(txBit)
);
`default_nettype wire

/* tb/hdtf_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hdtf_cfg.svh"
module hdtf_host_model (
	input wire logic mclk,
	output logic [`HDTF_ADDR_W-1:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWr,
	output logic regRd,
	input wire logic [7:0] regRdData
);
	// bus idle at time zero
	initial begin
		regAddr = 3'h0;
		regWrData = 8'h00;
		regWr = 1'b0;
		regRd = 1'b0;
	end
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
		regWrData <= ~d; // released data must not look valid
	endtask
	// answer stands only in the cycle after the strobe
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		@(negedge mclk);
		d = regRdData;
	endtask
	task automatic fill(input int n);
		for (int i = 0; i < n; i++) begin
			wr(`HDTF_OFS_DATA, 8'($urandom));
		end
	endtask
	// one block, then the command that marks it
	task automatic frame(input int n, input logic [7:0] cmd);
		fill(n);
		wr(`HDTF_OFS_CMD, cmd);
	endtask
endmodule
`default_nettype wire

/* tb/hdtf_tx_fifo_test.sv */
`timescale 1ns/1ns
`default_nettype none
`include "hdtf_cfg.svh"
module hdtf_tx_fifo_test;
	logic mclk, rst_b, bitEn, chanStop, txBit, bitEnQ, regWr, regRd;
	logic [2:0] regAddr;
	logic [7:0] regWrData, regRdData, v, lineSh;
	int mismatches, n_checks, cyc, ones, flagCnt, abortCnt, f0, a0;
	hdtf_tx_fifo #(.IS_D_CHAN(1'b1)) hdtf_tx_fifo_inst (.mclk(mclk), .rst_b(rst_b),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .bitEn(bitEn), .chanStop(chanStop), .txBit(txBit));
	hdtf_host_model host (.mclk(mclk), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData));
	function automatic logic [7:0] expStat(input logic ovf, input logic we);
		return {6'h00, ovf, we};
	endfunction
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic waitIrq(input logic [7:0] m, output logic [7:0] r);
		r = 8'h00;
		for (int i = 0; i < 400 && (r & m) == 8'h00; i++) host.rd(`HDTF_OFS_IRQ, r);
	endtask
	task automatic pulseStop();
		chanStop <= 1'b1;
		@(posedge mclk);
		chanStop <= 1'b0;
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// random bit slots, line monitor one edge behind, hang guard
	always @(posedge mclk) begin
		bitEnQ <= bitEn;
		bitEn <= 1'($urandom % 4 != 0);
		cyc++;
		if (cyc == 40000) begin
			mismatches++;
			results();
		end
		if (bitEnQ) begin
			lineSh <= {txBit, lineSh[7:1]};
			if ({txBit, lineSh[7:1]} == 8'h7e) flagCnt++;
			ones <= txBit ? ones + 1 : 0;
			if (txBit && ones == 6) abortCnt++;
		end
	end
	initial begin
		rst_b = 1'b0;
		bitEn = 1'b0;
		bitEnQ = 1'b0;
		chanStop = 1'b0;
		lineSh = 8'h00;
		void'($urandom(32'h700f));
		repeat (10) @(posedge mclk);
		rst_b <= 1'b1;
		host.rd(`HDTF_OFS_IRQ, v);
		chk("irq", 8'h00, v);
		host.rd(`HDTF_OFS_STAT, v);
		chk("status", expStat(1'b0, 1'b1), v);
		host.rd(`HDTF_OFS_EXM, v);
		chk("ext mode", 8'(`HDTF_EXM_RST), v);
		host.rd(3'h5, v);
		chk("unmapped", 8'h00, v);
		$display("test reset values done");
		a0 = abortCnt;
		host.wr(`HDTF_OFS_CMD, 8'h04);
		waitIrq(8'h01, v);
		chk("pool ready", 8'h01, v);
		host.rd(`HDTF_OFS_IRQ, v);
		chk("irq cleared", 8'h00, v);
		host.wr(`HDTF_OFS_EXM, 8'h01);
		host.fill(17);
		host.rd(`HDTF_OFS_STAT, v);
		chk("old block", expStat(1'b0, 1'b1), v);
		host.wr(`HDTF_OFS_CMD, 8'h04);
		host.fill(17);
		host.rd(`HDTF_OFS_STAT, v);
		chk("overflow", expStat(1'b1, 1'b1), v);
		host.wr(`HDTF_OFS_CMD, 8'h04);
		host.rd(`HDTF_OFS_STAT, v);
		chk("overflow cleared", expStat(1'b0, 1'b1), v);
		chk("abort", 8'h01, 8'(abortCnt > a0));
		$display("test reset and block size done");
		waitIrq(8'h01, v);
		a0 = abortCnt;
		host.frame(4, 8'h01);
		v = 8'h01;
		for (int i = 0; i < 400 && v[0] === 1'b1; i++) host.rd(`HDTF_OFS_STAT, v);
		chk("locked", expStat(1'b0, 1'b0), v);
		host.rd(`HDTF_OFS_IRQ, v);
		chk("underrun", 8'h03, v);
		host.rd(`HDTF_OFS_STAT, v);
		chk("unlocked", expStat(1'b0, 1'b1), v);
		chk("abort", 8'h01, 8'(abortCnt > a0));
		$display("test underrun done");
		host.wr(`HDTF_OFS_EXM, 8'h05);
		host.wr(`HDTF_OFS_CMD, 8'h04);
		waitIrq(8'h01, v);
		f0 = flagCnt;
		host.frame(1 + $urandom % 16, 8'h03);
		host.rd(`HDTF_OFS_STAT, v);
		chk("frame lock", expStat(1'b0, 1'b0), v);
		waitIrq(8'h01, v);
		chk("frame done", 8'h01, v);
		chk("flags", 8'h02, 8'(flagCnt - f0));
		$display("test whole frame done");
		f0 = flagCnt;
		host.frame(16, 8'h03);
		// long enough that the opening flag is out and data is on the line
		repeat (40) @(posedge mclk);
		pulseStop();
		waitIrq(8'h01, v);
		chk("retry", 8'h01, v);
		chk("retry flags", 8'h03, 8'(flagCnt - f0));
		// block 32 so the second block fills the buffer and must wait for a release
		host.wr(`HDTF_OFS_EXM, 8'h04);
		host.wr(`HDTF_OFS_CMD, 8'h04);
		waitIrq(8'h01, v);
		host.frame(32, 8'h01);
		waitIrq(8'h01, v);
		chk("space free", 8'h01, v);
		host.frame(32, 8'h01);
		waitIrq(8'h01, v);
		chk("block freed", 8'h01, v);
		pulseStop();
		waitIrq(8'h04, v);
		chk("repeat", 8'h04, v & 8'h04);
		$display("test collisions done");
		results();
	end
endmodule
`default_nettype wire
